// ==== rblt_test_ctrl.sv ====
// Test control block: register bank, RAM self-test launch and loopback test sequencer.
// Assumes an Avalon-MM master with waitrequest, a same-clock memory and word codec,
// and an asynchronous external test pin.
//
// Overview of operation
// - Pass flag on clean finish, cleared by go.
// - Fail flag on error, cleared by go.
// - Four quadrants tested together at equal offsets.
// - Failure register keeps lowest-quadrant address.
// - Bits seven and six ignore writes, read zero.
// - Analog select low: internal loop, bus undriven.
// - Analog select high: word out and back on bus.
// - Sync type one means command sync, else data.
// - Bus choice zero means bus A, one bus B.
// - Self-test go needs test pin and bit 15.
// - Self-test go clears itself on completion.
// - Loopback go needs test pin, self-clears.
// - Loopback fails on coding, parity, sync, data errors.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rblt_test_ctrl
   import rblt_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [7:0]    address,
   input  wire logic          read,
   input  wire logic          write,
   input  wire logic [31:0]   writedata,
   input  wire logic [3:0]    byteenable,
   output logic [31:0]        readdata,
   output logic               waitrequest,
   output logic               irq,
   input  wire logic          testPin,
   output rblt_ram_req_t      ramReq,
   input  wire rblt_ram_rd_t  ramRd,
   output rblt_lb_tx_t        lbTx,
   input  wire rblt_lb_rx_t   lbRx,
   output logic               busADriveEn,
   output logic               busBDriveEn
);

   // Test pin synchroniser and its filtered level.
   logic [2:0]           testSync, next_testSync;   // Three-stage capture of the pin.
   logic                 testLevel, next_testLevel; // Accepted level of the pin.

   // Register bank state.
   logic [15:0]          ctrl, next_ctrl;           // Test control register.
   logic [15:0]          lbTxData, next_lbTxData;   // Loopback transmit word.
   logic [15:0]          failAddr, next_failAddr;   // Self-test failure address.
   logic [IRQ_W-1:0]     irqStat, next_irqStat;     // Sticky event bits.
   logic [IRQ_W-1:0]     irqMask, next_irqMask;     // Interrupt enables.
   logic [31:0]          next_readdata;             // Read data loaded at request.
   logic                 next_waitrequest;          // Bus handshake.
   logic                 next_irq;                  // Interrupt line.

   // Loopback sequencer state.
   rblt_lb_state_t       lbState, next_lbState;     // Sequencer state.
   logic [LB_CNT_W-1:0]  lbCnt, next_lbCnt;         // Answer timeout counter.
   logic [15:0]          lbRxData, next_lbRxData;   // Last received loopback word.
   rblt_lb_tx_t          next_lbTx;                 // Next request to the codec.
   logic                 next_busADriveEn;          // Next bus A driver enable.
   logic                 next_busBDriveEn;          // Next bus B driver enable.
   logic                 lbFinish;                  // Loopback ends this cycle.
   logic                 lbBad;                     // Outcome of the ending loopback.

   // Bus decode helpers and self-test engine handshake.
   logic                 wrAck;                     // Write takes effect this edge.
   logic                 rdAck;                     // Read completes this edge.
   logic [15:0]          wrMask;                    // Byte lanes of the write.
   logic                 rbStart;                   // Accepted self-test launch.
   logic                 bistDone;                  // Engine completion pulse.
   logic                 bistFailed;                // Engine outcome.
   logic [QUAD_AW-1:0]   bistFailAddr;              // Engine failure offset.

   assign wrAck  = write && !waitrequest;
   assign rdAck  = read && !waitrequest;
   assign wrMask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

   // A launch is taken only from an idle engine, with the pin high and bit 15 already set.
   assign rbStart = wrAck && (address[7:2] == IDX_TEST_CTRL) && byteenable[1]
                    && writedata[TC_RB_GO] && testLevel && ctrl[TC_TEST_EN]
                    && !ctrl[TC_RB_GO];

   // The self-test engine walks the four quadrants in parallel.
   rblt_ram_bist u_bist (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .start      (rbStart),
      .patternSel (ctrl[TC_SEL_HI:TC_SEL_LO]),
      .ramReq     (ramReq),
      .ramRd      (ramRd),
      .done       (bistDone),
      .failed     (bistFailed),
      .failAddr   (bistFailAddr)
   );

   // Test pin capture: the level moves only once the second and third stages agree.
   // The first stage feeds the second alone, as it may be metastable.
   always_comb begin
      next_testSync  = {testSync[1:0], testPin};
      next_testLevel = testLevel;
      if (testSync[1] == testSync[2]) begin
         next_testLevel = testSync[2];
      end
   end

   // Registers of the pin capture.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         testSync  <= 3'h0;
         testLevel <= 1'b0;
      end else begin
         testSync  <= next_testSync;
         testLevel <= next_testLevel;
      end
   end

   // Register bank, bus handshake, result flags and interrupt status.
   always_comb begin
      next_ctrl        = ctrl;
      next_lbTxData    = lbTxData;
      next_failAddr    = failAddr;
      next_irqStat     = irqStat;
      next_irqMask     = irqMask;
      next_readdata    = readdata;
      // Waitrequest drops for one cycle after a request is seen, so each access takes two.
      next_waitrequest = !((read || write) && waitrequest);

      // Load read data while waitrequest is still high, so it stands at the completing edge.
      if (read && waitrequest) begin
         if (address[7:2] == IDX_TEST_CTRL) begin
            next_readdata = {16'h0000, ctrl};
         end else if (address[7:2] == IDX_LB_TX) begin
            next_readdata = {16'h0000, lbTxData};
         end else if (address[7:2] == IDX_LB_RX) begin
            next_readdata = {16'h0000, lbRxData};
         end else if (address[7:2] == IDX_FAIL_ADDR) begin
            next_readdata = {16'h0000, failAddr};
         end else if (address[7:2] == IDX_IRQ_STAT) begin
            next_readdata = {28'h0000000, irqStat};
         end else if (address[7:2] == IDX_IRQ_MASK) begin
            next_readdata = {28'h0000000, irqMask};
         end else begin
            // Unmapped slots read as zero and accept writes without effect.
            next_readdata = 32'h00000000;
         end
      end

      // Plain writes; reserved bits and the hardware-owned flags are masked off.
      if (wrAck) begin
         if (address[7:2] == IDX_TEST_CTRL) begin
            next_ctrl = (ctrl & ~(TC_WR_MASK & wrMask))
                        | (writedata[15:0] & TC_WR_MASK & wrMask);
         end else if (address[7:2] == IDX_LB_TX) begin
            next_lbTxData = (lbTxData & ~wrMask) | (writedata[15:0] & wrMask);
         end else if (address[7:2] == IDX_IRQ_MASK) begin
            next_irqMask = writedata[IRQ_W-1:0] & wrMask[IRQ_W-1:0];
         end
      end

      // Accepted self-test launch sets go and clears both result flags.
      if (rbStart) begin
         next_ctrl[TC_RB_GO]   = 1'b1;
         next_ctrl[TC_RB_PASS] = 1'b0;
         next_ctrl[TC_RB_FAIL] = 1'b0;
      end

      // Loopback launch needs only the test pin; a running test ignores further ones.
      if (wrAck && (address[7:2] == IDX_TEST_CTRL) && byteenable[0]
          && writedata[TC_LB_GO] && testLevel && !ctrl[TC_LB_GO]) begin
         next_ctrl[TC_LB_GO]   = 1'b1;
         next_ctrl[TC_LB_PASS] = 1'b0;
         next_ctrl[TC_LB_FAIL] = 1'b0;
      end

      // A read of the status register clears it; events below set after, so they win.
      if (rdAck && (address[7:2] == IDX_IRQ_STAT)) begin
         next_irqStat = IRQ_RESET;
      end

      // Self-test completion: go drops and exactly one result flag rises.
      if (bistDone) begin
         next_ctrl[TC_RB_GO]   = 1'b0;
         next_ctrl[TC_RB_PASS] = !bistFailed;
         next_ctrl[TC_RB_FAIL] = bistFailed;
         if (bistFailed) begin
            next_failAddr            = {3'h0, bistFailAddr};
            next_irqStat[IRQ_RB_FAIL] = 1'b1;
         end else begin
            next_irqStat[IRQ_RB_PASS] = 1'b1;
         end
      end

      // Loopback completion: go drops and the outcome is posted.
      if (lbFinish) begin
         next_ctrl[TC_LB_GO]   = 1'b0;
         next_ctrl[TC_LB_PASS] = !lbBad;
         next_ctrl[TC_LB_FAIL] = lbBad;
         if (lbBad) begin
            next_irqStat[IRQ_LB_FAIL] = 1'b1;
         end else begin
            next_irqStat[IRQ_LB_PASS] = 1'b1;
         end
      end

      // The line follows the next status value so it clears with the read that empties it.
      next_irq = |(next_irqStat & next_irqMask);
   end

   // Registers of the bank.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl        <= TC_RESET;
         lbTxData    <= REG_RESET;
         failAddr    <= REG_RESET;
         irqStat     <= IRQ_RESET;
         irqMask     <= IRQ_RESET;
         readdata    <= 32'h00000000;
         waitrequest <= 1'b1;
         irq         <= 1'b0;
      end else begin
         ctrl        <= next_ctrl;
         lbTxData    <= next_lbTxData;
         failAddr    <= next_failAddr;
         irqStat     <= next_irqStat;
         irqMask     <= next_irqMask;
         readdata    <= next_readdata;
         waitrequest <= next_waitrequest;
         irq         <= next_irq;
      end
   end

   // Loopback sequencer: one word out, one word back, compared against what was sent.
   always_comb begin
      next_lbState     = lbState;
      next_lbCnt       = lbCnt;
      next_lbRxData    = lbRxData;
      next_lbTx        = lbTx;
      next_lbTx.start  = 1'b0;
      next_busADriveEn = busADriveEn;
      next_busBDriveEn = busBDriveEn;
      lbFinish         = 1'b0;
      lbBad            = 1'b0;
      case (lbState)
         LB_IDLE: begin
            if (ctrl[TC_LB_GO]) begin
               next_lbState = LB_SEND;
            end
         end
         LB_SEND: begin
            // Options are frozen into the request for the whole test.
            next_lbTx.start   = 1'b1;
            next_lbTx.word    = lbTxData;
            next_lbTx.cmdSync = ctrl[TC_LB_SYNC];
            next_lbTx.busB    = ctrl[TC_LB_BUS];
            next_lbTx.analog  = ctrl[TC_LB_ANALOG];
            // Digital loopback keeps both drivers off; analog drives only the chosen bus.
            next_busADriveEn  = ctrl[TC_LB_ANALOG] && !ctrl[TC_LB_BUS];
            next_busBDriveEn  = ctrl[TC_LB_ANALOG] && ctrl[TC_LB_BUS];
            next_lbCnt        = '0;
            next_lbState      = LB_WAIT;
         end
         LB_WAIT: begin
            next_lbCnt = lbCnt + 1'b1;
            if (lbRx.valid) begin
               next_lbRxData = lbRx.word;
               lbFinish      = 1'b1;
               lbBad         = lbRx.manchErr || lbRx.parityErr
                               || (lbRx.cmdSync != lbTx.cmdSync)
                               || (lbRx.word != lbTx.word);
            end else if (lbCnt == LB_TIMEOUT_CYC - 1'b1) begin
               // A word that never returns is a failure too, else go would hang.
               lbFinish = 1'b1;
               lbBad    = 1'b1;
            end
            if (lbFinish) begin
               next_busADriveEn = 1'b0;
               next_busBDriveEn = 1'b0;
               next_lbState     = LB_IDLE;
            end
         end
         default: next_lbState = LB_IDLE;
      endcase
   end

   // Registers of the loopback sequencer.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lbState     <= LB_IDLE;
         lbCnt       <= '0;
         lbRxData    <= REG_RESET;
         lbTx        <= '0;
         busADriveEn <= 1'b0;
         busBDriveEn <= 1'b0;
      end else begin
         lbState     <= next_lbState;
         lbCnt       <= next_lbCnt;
         lbRxData    <= next_lbRxData;
         lbTx        <= next_lbTx;
         busADriveEn <= next_busADriveEn;
         busBDriveEn <= next_busBDriveEn;
      end
   end

endmodule
`default_nettype wire

// ==== rblt_pkg.sv ====
// Shared constants, types and state codes for the RAM self-test and loopback test controller.
// Assumes a single 50 MHz clock domain and a 32-bit Avalon-MM register bus with word-aligned slots.
package rblt_pkg;

   // Register indexes; the byte address of each register is four times its index.
   localparam logic [5:0] IDX_TEST_CTRL = 6'h17;   // Test control register.
   localparam logic [5:0] IDX_LB_TX     = 6'h18;   // Loopback transmit word.
   localparam logic [5:0] IDX_LB_RX     = 6'h19;   // Loopback receive word.
   localparam logic [5:0] IDX_FAIL_ADDR = 6'h1E;   // Self-test failure address.
   localparam logic [5:0] IDX_IRQ_STAT  = 6'h20;   // Sticky event status, cleared on read.
   localparam logic [5:0] IDX_IRQ_MASK  = 6'h21;   // Interrupt mask, same layout as status.

   // Bit positions inside the test control register.
   localparam int TC_TEST_EN   = 15;   // Test mode enable, gates the self-test go bit.
   localparam int TC_SEL_HI    = 13;   // Top bit of the pattern select field.
   localparam int TC_SEL_LO    = 11;   // Bottom bit of the pattern select field.
   localparam int TC_RB_GO     = 10;   // RAM self-test go.
   localparam int TC_RB_PASS   = 9;    // RAM self-test pass flag.
   localparam int TC_RB_FAIL   = 8;    // RAM self-test fail flag.
   localparam int TC_LB_ANALOG = 5;    // Loopback analog select.
   localparam int TC_LB_SYNC   = 4;    // Loopback sync type, one means command sync.
   localparam int TC_LB_BUS    = 3;    // Loopback bus choice, one means bus B.
   localparam int TC_LB_GO     = 2;    // Loopback go.
   localparam int TC_LB_PASS   = 1;    // Loopback pass flag.
   localparam int TC_LB_FAIL   = 0;    // Loopback fail flag.

   // Reset value and plain-write mask of the test control register; bits 14, 7 and 6 never set.
   localparam logic [15:0] TC_RESET    = 16'h0000;
   localparam logic [15:0] TC_WR_MASK  = 16'hB838;
   localparam logic [15:0] REG_RESET   = 16'h0000;

   // Interrupt status bit positions.
   localparam int IRQ_RB_PASS = 0;
   localparam int IRQ_RB_FAIL = 1;
   localparam int IRQ_LB_PASS = 2;
   localparam int IRQ_LB_FAIL = 3;
   localparam int IRQ_W       = 4;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

   // Memory geometry: four quadrants of 8K words tested side by side.
   localparam int QUAD_AW    = 13;
   localparam int QUAD_COUNT = 4;
   localparam logic [QUAD_AW-1:0] QUAD_LAST = 13'h1FFF;

   // Loopback answer timeout, in microseconds and in clock cycles.
   localparam int CLK_MHZ          = 50;
   localparam int LB_TIMEOUT_US    = 50;
   localparam int LB_CNT_W         = 12;
   localparam logic [LB_CNT_W-1:0] LB_TIMEOUT_CYC = LB_CNT_W'(LB_TIMEOUT_US * CLK_MHZ);

   // Request from the self-test engine to the memory; offset is inside each quadrant.
   typedef struct packed {
      logic [QUAD_AW-1:0] addr;
      logic [15:0]        wrData;
      logic               wrEn;
      logic               rdEn;
   } rblt_ram_req_t;

   // Read data from the four quadrants, lane 0 being the lowest quadrant.
   typedef struct packed {
      logic [QUAD_COUNT-1:0][15:0] lane;
   } rblt_ram_rd_t;

   // Loopback request to the word encoder and transceivers.
   typedef struct packed {
      logic        start;
      logic [15:0] word;
      logic        cmdSync;
      logic        busB;
      logic        analog;
   } rblt_lb_tx_t;

   // Loopback word returned by the decoder.
   typedef struct packed {
      logic        valid;
      logic [15:0] word;
      logic        cmdSync;
      logic        manchErr;
      logic        parityErr;
   } rblt_lb_rx_t;

   // Self-test engine states.
   typedef enum logic [2:0] {
      BS_IDLE  = 3'b000,
      BS_FILL  = 3'b001,
      BS_READ  = 3'b010,
      BS_WAIT  = 3'b011,
      BS_CHECK = 3'b100,
      BS_DONE  = 3'b101
   } rblt_bist_state_t;

   // Loopback sequencer states.
   typedef enum logic [1:0] {
      LB_IDLE = 2'b00,
      LB_SEND = 2'b01,
      LB_WAIT = 2'b10
   } rblt_lb_state_t;

   // Data background chosen by the pattern select field.
   function automatic logic [15:0] rblt_background(input logic [2:0] sel);
      logic [15:0] bg;
      bg = 16'h0000;
      case (sel)
         3'h1: bg = 16'h5555;
         3'h2: bg = 16'h3333;
         3'h3: bg = 16'h0F0F;
         3'h4: bg = 16'h00FF;
         3'h5: bg = 16'hAAAA;
         3'h6: bg = 16'hCCCC;
         3'h7: bg = 16'hF0F0;
         default: bg = 16'h0000;
      endcase
      return bg;
   endfunction

endpackage

// ==== rblt_ram_bist.sv ====
// RAM self-test engine: writes a background, verifies it, then repeats with its inverse.
// Assumes a synchronous memory that returns data one cycle after it samples a read request.
`timescale 1ns/1ps
`default_nettype none
module rblt_ram_bist
   import rblt_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               start,
   input  wire logic [2:0]         patternSel,
   output var  rblt_ram_req_t      ramReq,
   input  wire rblt_ram_rd_t       ramRd,
   output logic                    done,
   output logic                    failed,
   output logic [QUAD_AW-1:0]      failAddr
);

   rblt_bist_state_t   state, next_state;          // Sequencer state.
   logic [QUAD_AW-1:0] addr, next_addr;            // Offset under test, common to all quadrants.
   logic [15:0]        bg, next_bg;                // Background of the run.
   logic               inv, next_inv;              // Second pass writes the inverse.
   rblt_ram_req_t      next_ramReq;                // Next memory request.
   logic               next_done;                  // Completion pulse.
   logic               next_failed;                // Outcome of the run.
   logic [QUAD_AW-1:0] next_failAddr;              // Offset at the failure.
   logic [QUAD_COUNT-1:0] laneBad;                 // Per-quadrant mismatch.
   logic [15:0]        expWord;                    // Expected word this pass.

   assign expWord = bg ^ {16{inv}};

   // One comparator per quadrant; all four quadrants check the same offset at once.
   for (genvar q = 0; q < QUAD_COUNT; q++) begin : g_lane
      assign laneBad[q] = (ramRd.lane[q] != expWord);
   end

   // Next-state logic of the engine.
   always_comb begin
      next_state    = state;
      next_addr     = addr;
      next_bg       = bg;
      next_inv      = inv;
      next_ramReq   = '0;
      next_done     = 1'b0;
      next_failed   = failed;
      next_failAddr = failAddr;
      case (state)
         BS_IDLE: begin
            if (start) begin
               next_bg     = rblt_background(patternSel);
               next_inv    = 1'b0;
               next_addr   = '0;
               next_failed = 1'b0;
               next_state  = BS_FILL;
            end
         end
         BS_FILL: begin
            // Same offset goes to every quadrant, so one sweep covers the whole range.
            next_ramReq.addr   = addr;
            next_ramReq.wrData = expWord;
            next_ramReq.wrEn   = 1'b1;
            if (addr == QUAD_LAST) begin
               next_addr  = '0;
               next_state = BS_READ;
            end else begin
               next_addr = addr + 1'b1;
            end
         end
         BS_READ: begin
            next_ramReq.addr = addr;
            next_ramReq.rdEn = 1'b1;
            next_state       = BS_WAIT;
         end
         BS_WAIT: begin
            // The memory samples the request on this edge; data arrives after it.
            next_state = BS_CHECK;
         end
         BS_CHECK: begin
            if (|laneBad) begin
               // Only the lowest-quadrant offset is kept; software resolves the quadrant.
               next_failed   = 1'b1;
               next_failAddr = addr;
               next_state    = BS_DONE;
            end else if (addr != QUAD_LAST) begin
               next_addr  = addr + 1'b1;
               next_state = BS_READ;
            end else if (!inv) begin
               next_inv   = 1'b1;
               next_addr  = '0;
               next_state = BS_FILL;
            end else begin
               next_state = BS_DONE;
            end
         end
         BS_DONE: begin
            next_done  = 1'b1;
            next_state = BS_IDLE;
         end
         default: next_state = BS_IDLE;
      endcase
   end

   // Registers of the engine.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state    <= BS_IDLE;
         addr     <= '0;
         bg       <= 16'h0000;
         inv      <= 1'b0;
         ramReq   <= '0;
         done     <= 1'b0;
         failed   <= 1'b0;
         failAddr <= '0;
      end else begin
         state    <= next_state;
         addr     <= next_addr;
         bg       <= next_bg;
         inv      <= next_inv;
         ramReq   <= next_ramReq;
         done     <= next_done;
         failed   <= next_failed;
         failAddr <= next_failAddr;
      end
   end

endmodule
`default_nettype wire

// ==== rblt_chk.sv ====
// Checker for the test control block: bus timing, control word and loopback drive.
// Bound to every rblt_test_ctrl instance; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rblt_chk
   import rblt_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        irq,
   input wire rblt_lb_tx_t lbTx,
   input wire logic        busADriveEn,
   input wire logic        busBDriveEn
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // A read of the control word completes at this edge.
   wire ctrlRd = read && !waitrequest && address == 8'h5C;
   ans_next_a: assert property ($rose(read || write) |=> !waitrequest)
      else $error("bus answer late");
   wait_one_a: assert property (!waitrequest |=> waitrequest)
      else $error("bus answer too long");
   bits_zero_a: assert property (ctrlRd |-> readdata[7:6] == 2'b00)
      else $error("unused bits read nonzero");
   one_flag_a: assert property (ctrlRd |-> !(readdata[9] && readdata[8]))
      else $error("pass and fail both set");
   drive_bus_a: assert property (lbTx.start |-> busADriveEn == (lbTx.analog && !lbTx.busB) &&
      busBDriveEn == (lbTx.analog && lbTx.busB)) else $error("wrong drive enable");
   no_drive_a: assert property (!lbTx.analog |-> !busADriveEn && !busBDriveEn)
      else $error("bus driven in digital loop");
   bus_b_a: assert property ($rose(busBDriveEn) |-> lbTx.busB && lbTx.analog)
      else $error("bus B driven unasked");
   start_pulse_a: assert property (lbTx.start |=> !lbTx.start)
      else $error("start longer than one cycle");
   irq_clear_a: assert property (read && !waitrequest && address == 8'h80 |=> ##1 !irq)
      else $error("irq stays after status read");
endmodule
bind rblt_test_ctrl rblt_chk u_chk(.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .lbTx(lbTx),
   .busADriveEn(busADriveEn), .busBDriveEn(busBDriveEn));
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for rblt_test_ctrl through its Avalon-MM slave port.
// Assumes rblt_chk is bound by its own file; memory and codec sides are driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module tb
   import rblt_pkg::*;
;
   logic          ref_clk = 0, rst = 1, read = 0, write = 0, testPin = 0;
   logic [7:0]    address = 8'h00;
   logic [31:0]   writedata = 32'h0, readdata, q;
   logic          waitrequest, irq, busADriveEn, busBDriveEn;
   rblt_ram_req_t ramReq;
   rblt_ram_rd_t  ramRd = '0;
   rblt_lb_tx_t   lbTx;
   rblt_lb_rx_t   lbRx = '0;
   int            num_errors = 0, checks_done = 0;
   logic [5:0]    cfg [6] = '{6'h00, 6'h38, 6'h20, 6'h10, 6'h18, 6'h08};
   int            err [6] = '{0, 0, 1, 2, 3, 4};
   always #10 ref_clk = ~ref_clk;
   // Memory answers zero, except one bad cell at offset 5 of the third quadrant.
   always @(posedge ref_clk)
      ramRd.lane[2] <= (ramReq.rdEn && ramReq.addr == 13'h0005) ? 16'hFFFF : 16'h0000;
   rblt_test_ctrl dut(.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .testPin(testPin), .ramReq(ramReq), .ramRd(ramRd),
      .lbTx(lbTx), .lbRx(lbRx), .busADriveEn(busADriveEn), .busBDriveEn(busBDriveEn));
   // One bus access, held until waitrequest is sampled low.
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      address <= a;
      writedata <= {16'h0000, d};
      write <= w;
      read <= !w;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 16'h0000);
      `CHK(q, e)
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // The whole run needs about 20k cycles; 50k means a hang.
   initial begin
      #1000000;
      num_errors++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rd(8'h5C, 32'h0);
      rd(8'h78, 32'h0);
      // With the pin low, both go bits and the unused bits must stay clear.
      acc(1'b1, 8'h5C, 16'hFFFF);
      rd(8'h5C, 32'h0000B838);
      rd(8'hFC, 32'h0);
      acc(1'b1, 8'h84, 16'h000F);
      acc(1'b1, 8'h60, 16'hA5C3);
      testPin <= 1'b1;
      repeat (5) @(posedge ref_clk);
      // Each case picks loop options and at most one kind of reply fault; the first two reply cleanly.
      for (int i = 0; i < 6; i++) begin
         acc(1'b1, 8'h5C, {10'h200, cfg[i] | 6'h04});
         do @(posedge ref_clk); while (lbTx.start !== 1'b1);
         `CHK({lbTx.word, lbTx.analog, lbTx.cmdSync, lbTx.busB}, {16'hA5C3, cfg[i][5:3]})
         `CHK({busADriveEn, busBDriveEn}, {cfg[i][5] & !cfg[i][3], cfg[i][5] & cfg[i][3]})
         lbRx <= '{1'b1, 16'hA5C3 ^ {15'h0, err[i] == 4}, cfg[i][4] ^ (err[i] == 3),
            err[i] == 2, err[i] == 1};
         @(posedge ref_clk);
         lbRx.valid <= 1'b0;
         repeat (3) @(posedge ref_clk);
         `CHK(irq, 1'b1)
         rd(8'h5C, {16'h0, 10'h200, cfg[i] | {4'h0, err[i] == 0, err[i] != 0}});
         rd(8'h80, err[i] != 0 ? 32'h8 : 32'h4);
         repeat (3) @(posedge ref_clk);
         `CHK(irq, 1'b0)
      end
      // Self-test stops at the bad cell; the lowest-quadrant offset is reported.
      acc(1'b1, 8'h5C, 16'h8400);
      do @(posedge ref_clk); while (irq !== 1'b1);
      rd(8'h5C, 32'h00008101);
      rd(8'h78, 32'h00000005);
      rd(8'h80, 32'h00000002);
      // A second launch must clear the old outcome while the run is under way.
      acc(1'b1, 8'h5C, 16'h8400);
      rd(8'h5C, 32'h00008401);
      do @(posedge ref_clk); while (irq !== 1'b1);
      rd(8'h80, 32'h00000002);
      summarize();
   end
endmodule
`default_nettype wire
